// File: hdl/cfr_config_regs.sv
`timescale 1ns/1ps

// Function
// - second control register is reserved; writes ignored, reads give zero
// - every frame is 2592 bits, 81 words of 32 bits, both halves
// - frame address written directly or advanced after each completed frame
// - bits 23:21 block type: logic/io/clock, block RAM, special logic
// - bit 20 selects half: zero top rows, one bottom rows
// - bits 19:15 row, counted from centre outward in each half
// - bits 14:7 major column from left; bits 6:0 minor frame
// - status register readable by the external host
// - status bit 31 shows fuse logic busy
// - status bit 29 flags bad packet seen during first configuration
// - bits 26:25 bus width, internal port width when enabled and done
// - bits 20:18 startup phase as gray code
// - bit 16 flags frame data write outside decryption
// - bit 15 flags frame data write without identity check
// - bit 14 completion pin level, bit 13 internal completion release
// - bit 12 init pin level, bit 11 initialization finished
// - bits 10:8 mode pins, bit 28 pull-up pin, 24:22 flash kind
// - bits 7, 6, 5 show global high, write permit, tristate
// - bit 4 shows end of startup
// - bit 3 ANDs bank impedance matches, banks without control give one
// - bit 2 ANDs clock manager locks, unused managers give one
// - bit 1 security set, bit 0 checksum error, bit 17 overheat
module cfr_config_regs #(
    parameter logic [6:0] LAST_MINOR  = 7'h23,
    parameter logic [7:0] LAST_COLUMN = 8'h1f,
    parameter logic [4:0] LAST_ROW    = 5'h03
) (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic [4:0]                    reg_index,
    input  wire logic                          reg_write,
    input  wire logic                          reg_read,
    input  wire logic [31:0]                   reg_wdata,
    output logic      [31:0]                   reg_rdata,
    output logic                               reg_rvalid,
    output logic      [31:0]                   frame_location,
    output logic                               frame_done,
    input  wire logic                          fuse_logic_busy,
    input  wire logic                          first_config,
    input  wire logic                          bad_packet_seen,
    input  wire logic [1:0]                    detected_width,
    input  wire logic                          internal_config_port_en,
    input  wire logic [1:0]                    internal_config_port_width,
    input  wire logic                          config_done,
    input  wire logic [2:0]                    serial_flash_kind,
    input  wire logic [2:0]                    startup_phase,
    input  wire logic                          overheat_alarm,
    input  wire logic                          decrypt_enabled,
    input  wire logic                          decrypt_active,
    input  wire logic                          part_identity_check,
    input  wire logic                          done_pin,
    input  wire logic                          release_done,
    input  wire logic                          init_pin,
    input  wire logic                          init_complete,
    input  wire logic [2:0]                    mode_pins,
    input  wire logic                          pullup_swap_pin_level,
    input  wire logic                          global_high_n,
    input  wire logic                          global_write_permit,
    input  wire logic                          global_tristate_n,
    input  wire logic                          startup_finished,
    input  wire logic [cfr_pkg::NUM_BANKS-1:0] bank_match,
    input  wire logic [cfr_pkg::NUM_BANKS-1:0] bank_has_ctrl,
    input  wire logic [cfr_pkg::NUM_CLKMGR-1:0] clkmgr_locked,
    input  wire logic [cfr_pkg::NUM_CLKMGR-1:0] clkmgr_used,
    input  wire logic                          decryptor_security_set,
    input  wire logic                          checksum_error,
    input  wire logic                          restart_config
);

    // ****************************************
    // decode
    // ****************************************
    logic        far_wr;
    logic        data_wr;
    logic        last_word;
    logic [31:0] far_ff;
    logic [31:0] nxt_far;
    logic [6:0]  word_ff;
    logic        done_ff;

    assign far_wr    = reg_write && reg_index == cfr_pkg::IDX_FRAME_LOCATION;
    assign data_wr   = reg_write && reg_index == cfr_pkg::IDX_FRAME_DATA_INPUT;
    assign last_word = word_ff == cfr_pkg::LAST_WORD;

    // ****************************************
    // pins from outside the clock domain
    // ****************************************
    logic [5:0] pins_sync;

    cfr_pin_sync #(
        .WIDTH (6)
    ) cfr_pin_sync_inst (
        .clock    (clock),
        .reset    (reset),
        .pin_in   ({pullup_swap_pin_level, mode_pins, init_pin, done_pin}),
        .pin_sync (pins_sync)
    );

    // ****************************************
    // frame word counter
    // ****************************************
    always_ff @(posedge clock) begin
        if (reset || far_wr) begin
            word_ff <= 7'h00;
        end else if (data_wr) begin
            word_ff <= last_word ? 7'h00 : word_ff + 7'h01;
        end
    end

    // ****************************************
    // frame address advance
    // ****************************************
    always_comb begin
        nxt_far = far_ff;
        if (far_ff[cfr_pkg::MIN_HI:cfr_pkg::MIN_LO] != LAST_MINOR) begin
            nxt_far[cfr_pkg::MIN_HI:cfr_pkg::MIN_LO] =
                far_ff[cfr_pkg::MIN_HI:cfr_pkg::MIN_LO] + 7'h01;
        end else begin
            nxt_far[cfr_pkg::MIN_HI:cfr_pkg::MIN_LO] = 7'h00;
            if (far_ff[cfr_pkg::COL_HI:cfr_pkg::COL_LO] != LAST_COLUMN) begin
                nxt_far[cfr_pkg::COL_HI:cfr_pkg::COL_LO] =
                    far_ff[cfr_pkg::COL_HI:cfr_pkg::COL_LO] + 8'h01;
            end else begin
                nxt_far[cfr_pkg::COL_HI:cfr_pkg::COL_LO] = 8'h00;
                if (far_ff[cfr_pkg::ROW_HI:cfr_pkg::ROW_LO] != LAST_ROW) begin
                    nxt_far[cfr_pkg::ROW_HI:cfr_pkg::ROW_LO] =
                        far_ff[cfr_pkg::ROW_HI:cfr_pkg::ROW_LO] + 5'h01;
                end else begin
                    // rows restart at the centre of the other half
                    nxt_far[cfr_pkg::ROW_HI:cfr_pkg::ROW_LO] = 5'h00;
                    nxt_far[cfr_pkg::HALF] = ~far_ff[cfr_pkg::HALF];
                    if (far_ff[cfr_pkg::HALF]) begin
                        // an ordinary load never walks into the special type
                        if (far_ff[cfr_pkg::BT_HI:cfr_pkg::BT_LO] ==
                            cfr_pkg::BLK_LOGIC_IO_CLK) begin
                            nxt_far[cfr_pkg::BT_HI:cfr_pkg::BT_LO] =
                                cfr_pkg::BLK_BRAM_CONTENT;
                        end else begin
                            nxt_far[cfr_pkg::BT_HI:cfr_pkg::BT_LO] =
                                cfr_pkg::BLK_LOGIC_IO_CLK;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            far_ff <= cfr_pkg::FAR_RESET;
        end else if (far_wr) begin
            far_ff <= reg_wdata;
        end else if (data_wr && last_word) begin
            far_ff <= nxt_far;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= data_wr && last_word && !far_wr;
        end
    end

    assign frame_location = far_ff;
    assign frame_done     = done_ff;

    // ****************************************
    // sticky error flags, set wins over clear
    // ****************************************
    logic bad_pkt_ff;
    logic dec_fault_ff;
    logic id_fault_ff;
    logic crc_err_ff;
    logic dec_set;
    logic id_set;

    assign dec_set = data_wr && decrypt_enabled && !decrypt_active;
    assign id_set  = data_wr && !part_identity_check;

    always_ff @(posedge clock) begin
        if (reset) begin
            bad_pkt_ff <= 1'b0;
        end else begin
            bad_pkt_ff <= (bad_packet_seen && first_config) ||
                          (bad_pkt_ff && !restart_config);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            dec_fault_ff <= 1'b0;
            id_fault_ff  <= 1'b0;
        end else begin
            dec_fault_ff <= dec_set || (dec_fault_ff && !restart_config);
            id_fault_ff  <= id_set || (id_fault_ff && !restart_config);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            crc_err_ff <= 1'b0;
        end else begin
            crc_err_ff <= checksum_error ||
                          (crc_err_ff && !restart_config);
        end
    end

    // ****************************************
    // aggregated match and lock
    // ****************************************
    logic [cfr_pkg::NUM_BANKS-1:0]  bank_term;
    logic [cfr_pkg::NUM_CLKMGR-1:0] lock_term;

    genvar gi;
    generate
        for (gi = 0; gi < cfr_pkg::NUM_BANKS; gi++) begin : g_bank
            assign bank_term[gi] = bank_match[gi] || !bank_has_ctrl[gi];
        end
        for (gi = 0; gi < cfr_pkg::NUM_CLKMGR; gi++) begin : g_lock
            assign lock_term[gi] = clkmgr_locked[gi] || !clkmgr_used[gi];
        end
    endgenerate

    // ****************************************
    // status word
    // ****************************************
    logic [31:0] status_word;
    logic [1:0]  width_sel;

    always_comb begin
        width_sel = detected_width;
        if (internal_config_port_en && config_done) begin
            width_sel = internal_config_port_width;
        end
    end

    always_comb begin
        status_word = cfr_pkg::READ_ZERO;
        status_word[cfr_pkg::ST_FUSE_BUSY]  = fuse_logic_busy;
        status_word[cfr_pkg::ST_BAD_PACKET] = bad_pkt_ff;
        status_word[cfr_pkg::ST_PULLUP_PIN] = pins_sync[5];
        status_word[cfr_pkg::ST_WIDTH_HI:cfr_pkg::ST_WIDTH_LO] =
            width_sel;
        status_word[cfr_pkg::ST_FLASH_HI:cfr_pkg::ST_FLASH_LO] =
            serial_flash_kind;
        status_word[cfr_pkg::ST_PHASE_HI:cfr_pkg::ST_PHASE_LO] =
            startup_phase ^ (startup_phase >> 1);
        status_word[cfr_pkg::ST_OVERHEAT]   = overheat_alarm;
        status_word[cfr_pkg::ST_DEC_FAULT]  = dec_fault_ff;
        status_word[cfr_pkg::ST_ID_FAULT]   = id_fault_ff;
        status_word[cfr_pkg::ST_DONE_PIN]   = pins_sync[0];
        status_word[cfr_pkg::ST_REL_DONE]   = release_done;
        status_word[cfr_pkg::ST_INIT_PIN]   = pins_sync[1];
        status_word[cfr_pkg::ST_INIT_DONE]  = init_complete;
        status_word[cfr_pkg::ST_MODE_HI:cfr_pkg::ST_MODE_LO] =
            pins_sync[4:2];
        status_word[cfr_pkg::ST_GHIGH_N]    = global_high_n;
        status_word[cfr_pkg::ST_WR_PERMIT]  = global_write_permit;
        status_word[cfr_pkg::ST_GTS_N]      = global_tristate_n;
        status_word[cfr_pkg::ST_UP_DONE]    = startup_finished;
        status_word[cfr_pkg::ST_MATCH_ALL]  = &bank_term;
        status_word[cfr_pkg::ST_LOCK_ALL]   = &lock_term;
        status_word[cfr_pkg::ST_SECURED]    = decryptor_security_set;
        status_word[cfr_pkg::ST_CRC_ERR]    = crc_err_ff;
    end

    // ****************************************
    // read port
    // ****************************************
    logic [31:0] rdata_ff;
    logic        rvalid_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            rdata_ff  <= cfr_pkg::READ_ZERO;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_read;
            if (reg_read) begin
                // reserved and unmapped registers read as zero
                case (reg_index)
                    cfr_pkg::IDX_FRAME_LOCATION: rdata_ff <= far_ff;
                    cfr_pkg::IDX_CONFIG_STATE:   rdata_ff <= status_word;
                    default:                     rdata_ff <= cfr_pkg::READ_ZERO;
                endcase
            end
        end
    end

    assign reg_rdata  = rdata_ff;
    assign reg_rvalid = rvalid_ff;

    // ****************************************
    // checks
    // ****************************************
    far_load_a: assert property (@(posedge clock) disable iff (reset)
        far_wr |=> far_ff == $past(reg_wdata))
        else $error("frame address not loaded by direct write");

    frame_len_a: assert property (@(posedge clock) disable iff (reset)
        (data_wr && !far_wr && word_ff == cfr_pkg::LAST_WORD) |=>
        (word_ff == 7'h00 && frame_done && far_ff != $past(far_ff)))
        else $error("frame of 81 words did not advance the address");

    mid_frame_a: assert property (@(posedge clock) disable iff (reset)
        (data_wr && !far_wr && word_ff < cfr_pkg::LAST_WORD) |=>
        $stable(far_ff))
        else $error("address moved before frame end");

    stat_read_a: assert property (@(posedge clock) disable iff (reset)
        (reg_read && reg_index == cfr_pkg::IDX_CONFIG_STATE) |=>
        (reg_rvalid && reg_rdata == $past(status_word)))
        else $error("status read returned wrong word");

    rsvd_read_a: assert property (@(posedge clock) disable iff (reset)
        (reg_read && reg_index == cfr_pkg::IDX_RESERVED_CTL_TWO) |=>
        reg_rdata == 32'h0000_0000)
        else $error("reserved register read nonzero");

    stat_ro_a: assert property (@(posedge clock) disable iff (reset)
        (reg_write && reg_index == cfr_pkg::IDX_CONFIG_STATE &&
         !restart_config && !dec_set && !id_set) |=>
        (dec_fault_ff == $past(dec_fault_ff) &&
         id_fault_ff == $past(id_fault_ff) && $stable(far_ff)))
        else $error("write to status changed state");

    gray_phase_a: assert property (@(posedge clock) disable iff (reset)
        startup_phase == 3'h6 |-> status_word[20:18] == 3'h5)
        else $error("startup phase gray code wrong");

    id_fault_a: assert property (@(posedge clock) disable iff (reset)
        (data_wr && !part_identity_check) |=> status_word[15])
        else $error("identity fault not held");

    dec_fault_a: assert property (@(posedge clock) disable iff (reset)
        (data_wr && decrypt_enabled && decrypt_active && !dec_fault_ff)
        |=> !dec_fault_ff)
        else $error("decrypt fault during decryption");

    bad_pkt_a: assert property (@(posedge clock) disable iff (reset)
        (bad_packet_seen && first_config) |=> status_word[29])
        else $error("bad packet not flagged");

    match_all_a: assert property (@(posedge clock) disable iff (reset)
        ((bank_match | ~bank_has_ctrl) != 8'hff) |-> !status_word[3])
        else $error("impedance match AND wrong");

    lock_all_a: assert property (@(posedge clock) disable iff (reset)
        ((clkmgr_locked | ~clkmgr_used) == 4'hf) |-> status_word[2])
        else $error("clock manager lock AND wrong");

endmodule : cfr_config_regs

// File: hdl/cfr_pin_sync.sv
`timescale 1ns/1ps

module cfr_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);

    // ****************************************
    // two-stage synchroniser, first stage feeds only the second
    // ****************************************
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge clock) begin
        if (reset) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    assign pin_sync = sync_ff;

endmodule : cfr_pin_sync

// File: hdl/cfr_pkg.sv
package cfr_pkg;

    // ****************************************
    // register indices on the configuration port
    // ****************************************
    localparam logic [4:0] IDX_FRAME_LOCATION   = 5'h01;
    localparam logic [4:0] IDX_FRAME_DATA_INPUT = 5'h02;
    localparam logic [4:0] IDX_CONFIG_STATE     = 5'h07;
    localparam logic [4:0] IDX_RESERVED_CTL_TWO = 5'h18;

    // ****************************************
    // frame geometry
    // ****************************************
    localparam int         FRAME_BITS  = 2592;
    localparam int         WORD_BITS   = 32;
    localparam logic [6:0] FRAME_WORDS = 7'(FRAME_BITS / WORD_BITS);
    localparam logic [6:0] LAST_WORD   = FRAME_WORDS - 7'h01;

    // ****************************************
    // frame_location fields
    // ****************************************
    localparam int BT_HI   = 23;
    localparam int BT_LO   = 21;
    localparam int HALF    = 20;
    localparam int ROW_HI  = 19;
    localparam int ROW_LO  = 15;
    localparam int COL_HI  = 14;
    localparam int COL_LO  = 7;
    localparam int MIN_HI  = 6;
    localparam int MIN_LO  = 0;
    localparam logic [2:0]  BLK_LOGIC_IO_CLK     = 3'h0;
    localparam logic [2:0]  BLK_BRAM_CONTENT     = 3'h1;
    localparam logic [2:0]  LOGIC_CFG_BLOCK_KIND = 3'h2;
    localparam logic [31:0] FAR_RESET            = 32'h0000_0000;
    localparam logic [31:0] READ_ZERO            = 32'h0000_0000;

    // ****************************************
    // config_state_report bit positions
    // ****************************************
    localparam int ST_FUSE_BUSY  = 31;
    localparam int ST_BAD_PACKET = 29;
    localparam int ST_PULLUP_PIN = 28;
    localparam int ST_WIDTH_HI   = 26;
    localparam int ST_WIDTH_LO   = 25;
    localparam int ST_FLASH_HI   = 24;
    localparam int ST_FLASH_LO   = 22;
    localparam int ST_PHASE_HI   = 20;
    localparam int ST_PHASE_LO   = 18;
    localparam int ST_OVERHEAT   = 17;
    localparam int ST_DEC_FAULT  = 16;
    localparam int ST_ID_FAULT   = 15;
    localparam int ST_DONE_PIN   = 14;
    localparam int ST_REL_DONE   = 13;
    localparam int ST_INIT_PIN   = 12;
    localparam int ST_INIT_DONE  = 11;
    localparam int ST_MODE_HI    = 10;
    localparam int ST_MODE_LO    = 8;
    localparam int ST_GHIGH_N    = 7;
    localparam int ST_WR_PERMIT  = 6;
    localparam int ST_GTS_N      = 5;
    localparam int ST_UP_DONE    = 4;
    localparam int ST_MATCH_ALL  = 3;
    localparam int ST_LOCK_ALL   = 2;
    localparam int ST_SECURED    = 1;
    localparam int ST_CRC_ERR    = 0;

    // ****************************************
    // system sizes
    // ****************************************
    localparam int NUM_BANKS  = 8;
    localparam int NUM_CLKMGR = 4;

endpackage : cfr_pkg

// File: verif/cfr_config_regs_tb.sv
`timescale 1ns/1ps

module cfr_config_regs_tb;
    localparam logic [4:0]  FL = cfr_pkg::IDX_FRAME_LOCATION;
    localparam logic [4:0]  FD = cfr_pkg::IDX_FRAME_DATA_INPUT;
    localparam logic [4:0]  ST = cfr_pkg::IDX_CONFIG_STATE;
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    // reserved status bits 30, 27, 21 are not judged
    localparam logic [31:0] SM = 32'hB7DF_FFFF;
    localparam logic [2:0]  GRAY [8] = '{3'h0, 3'h1, 3'h3, 3'h2,
                                         3'h6, 3'h7, 3'h5, 3'h4};
    localparam logic [31:0] F_IN [4] = '{32'h0000_0001, 32'h0000_0081,
                                         32'h0000_8081, 32'h0050_8081};
    localparam logic [31:0] F_EX [4] = '{32'h0000_0080, 32'h0000_8000,
                                         32'h0010_0000, 32'h0000_0000};
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [4:0]  reg_index;
    logic        reg_write, reg_read, reg_rvalid, frame_done;
    logic [31:0] reg_wdata, reg_rdata, frame_location;
    logic fuse_logic_busy = '0, first_config = '0, bad_packet_seen = '0;
    logic internal_config_port_en = '0, config_done = '0, done_pin = '0;
    logic overheat_alarm = '0, decrypt_enabled = '0, decrypt_active = '0;
    logic part_identity_check = '1, release_done = '0, init_pin = '0;
    logic init_complete = '0, pullup_swap_pin_level = '0, global_high_n = '0;
    logic global_write_permit = '0, global_tristate_n = '0;
    logic startup_finished = '0, decryptor_security_set = '0;
    logic checksum_error = '0, restart_config = '0;
    logic [1:0] detected_width = '0, internal_config_port_width = '0;
    logic [2:0] serial_flash_kind = '0, startup_phase = '0, mode_pins = '0;
    logic [7:0] bank_match = '0, bank_has_ctrl = '0;
    logic [3:0] clkmgr_locked = '0, clkmgr_used = '0;
    logic s29 = '0, s16 = '0, s15 = '0, s0 = '0;
    int   err_total = 0, cmp_count = 0, fd_cnt = 0, cyc = 0;

    cfr_config_regs #(.LAST_MINOR(7'h01), .LAST_COLUMN(8'h01),
        .LAST_ROW(5'h01)) cfr_config_regs_inst (.*);
    cfr_host_model cfr_host_model_inst (.*);

    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (frame_done === 1'b1) fd_cnt <= fd_cnt + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    // ****************************************
    // expected status and checking helpers
    // ****************************************
    function automatic logic [31:0] exp_st();
        logic [1:0] w;
        w = (internal_config_port_en && config_done) ?
            internal_config_port_width : detected_width;
        return {fuse_logic_busy, 1'b0, s29, pullup_swap_pin_level, 1'b0, w,
            serial_flash_kind, 1'b0, GRAY[startup_phase],
            overheat_alarm, s16, s15, done_pin, release_done, init_pin,
            init_complete, mode_pins, global_high_n, global_write_permit,
            global_tristate_n, startup_finished,
            &(bank_match | ~bank_has_ctrl), &(clkmgr_locked | ~clkmgr_used),
            decryptor_security_set, s0};
    endfunction : exp_st

    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task rc(input logic [4:0] i, input logic [31:0] e, input logic [31:0] m);
        logic [31:0] d;
        cfr_host_model_inst.rd(i, d);
        chk(d & m, e & m);
    endtask : rc

    task st_chk();
        // pin bits need two edges through the synchroniser
        repeat (3) @(posedge clock);
        rc(ST, exp_st(), SM);
    endtask : st_chk

    // w bits: 0 bad packet, 1 checksum error, 2 restart
    task pulse(input logic [2:0] w);
        @(posedge clock);
        #1;
        {restart_config, checksum_error, bad_packet_seen} = w;
        @(posedge clock);
        #1;
        {restart_config, checksum_error, bad_packet_seen} = 3'h0;
    endtask : pulse

    task frame(input int n);
        repeat (n) cfr_host_model_inst.wr(FD, 32'h1234_5678);
    endtask : frame

    task t_ro();
        logic [31:0] s;
        cfr_host_model_inst.rd(ST, s);
        cfr_host_model_inst.wr(ST, ~s);
        rc(ST, exp_st(), SM);
        cfr_host_model_inst.wr(cfr_pkg::IDX_RESERVED_CTL_TWO, ALL);
        rc(cfr_pkg::IDX_RESERVED_CTL_TWO, 32'h0000_0000, ALL);
        rc(5'h1f, 32'h0000_0000, ALL);
    endtask : t_ro

    task t_stat();
        logic [2:0] b;
        for (int k = 0; k < 8; k++) begin
            b = 3'(k);
            startup_phase = b;
            fuse_logic_busy = b[0];
            detected_width = b[1:0];
            internal_config_port_en = b[2];
            internal_config_port_width = ~b[1:0];
            config_done = b[1];
            serial_flash_kind = ~b;
            overheat_alarm = b[1];
            {done_pin, release_done, init_pin} = b;
            {init_complete, pullup_swap_pin_level, global_high_n} = ~b;
            {global_write_permit, global_tristate_n, startup_finished} =
                {b[1:0], b[2]};
            mode_pins = b ^ 3'h5;
            decryptor_security_set = b[2];
            bank_has_ctrl = 8'hF0;
            bank_match = b[0] ? 8'hF0 : 8'h70;
            clkmgr_used = 4'h3;
            clkmgr_locked = b[1] ? 4'h3 : 4'hD;
            st_chk();
        end
    endtask : t_stat

    task t_sticky();
        first_config = 1'b1;
        pulse(3'h1);
        pulse(3'h2);
        {s29, s0} = 2'h3;
        st_chk();
        pulse(3'h4);
        {s29, s0} = 2'h0;
        first_config = 1'b0;
        pulse(3'h1);
        st_chk();
        part_identity_check = 1'b0;
        frame(1);
        s15 = 1'b1;
        part_identity_check = 1'b1;
        {decrypt_enabled, decrypt_active} = 2'h3;
        frame(1);
        st_chk();
        decrypt_active = 1'b0;
        frame(1);
        s16 = 1'b1;
        st_chk();
        pulse(3'h4);
        {s16, s15, decrypt_enabled} = 3'h0;
        st_chk();
    endtask : t_sticky

    task t_far();
        int f0;
        cfr_host_model_inst.wr(FL, 32'h0030_8081);
        rc(FL, 32'h0030_8081, ALL);
        chk(frame_location, 32'h0030_8081);
        f0 = fd_cnt;
        frame(80);
        repeat (3) @(posedge clock);
        #1;
        chk(32'(fd_cnt - f0), 32'h0000_0000);
        frame(1);
        repeat (2) @(posedge clock);
        #1;
        chk(32'(fd_cnt - f0), 32'h0000_0001);
        chk(frame_location, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            cfr_host_model_inst.wr(FL, F_IN[k]);
            frame(81);
            repeat (2) @(posedge clock);
            #1;
            chk(frame_location, F_EX[k]);
        end
    endtask : t_far

    task summarize();
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    initial begin
        repeat (6) @(posedge clock);
        #1;
        reset = 1'b0;
        rc(FL, cfr_pkg::FAR_RESET, ALL);
        t_ro();
        t_stat();
        t_sticky();
        t_far();
        summarize();
    end
endmodule : cfr_config_regs_tb

// File: verif/cfr_host_model.sv
`timescale 1ns/1ps

module cfr_host_model (
    input  wire logic        clock,
    output logic      [4:0]  reg_index,
    output logic             reg_write,
    output logic             reg_read,
    output logic      [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    initial begin
        reg_index = 5'h00;
        reg_write = 1'b0;
        reg_read  = 1'b0;
        reg_wdata = 32'h0000_0000;
    end

    task wr(input logic [4:0] idx, input logic [31:0] d);
        @(posedge clock);
        #1;
        reg_index = idx;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
        // idle data is inverted so a stale word never passes as fresh
        reg_wdata = ~d;
    endtask : wr

    task rd(input logic [4:0] idx, output logic [31:0] d);
        @(posedge clock);
        #1;
        reg_index = idx;
        reg_read  = 1'b1;
        @(posedge clock);
        #1;
        reg_read = 1'b0;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxx_xxxx;
    endtask : rd
endmodule : cfr_host_model
